// ===== core/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
  // ==========================================================
  // mode codes
  typedef enum logic [2:0]
  {
    MODE_STANDBY = 3'b000,
    MODE_FIXED5V = 3'b001,
    MODE_ASSIST = 3'b010,
    MODE_FLASH = 3'b011,
    MODE_INDEP_TO = 3'b100,
    MODE_INDEP_NOTO = 3'b101,
    MODE_5V_TORCH = 3'b110,
    MODE_RESERVED = 3'b111
  } op_mode_t;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  // flash step per duration code: 100 ms, code 15 gives 1.6 s
  localparam int unsigned FLASH_STEP_MS = 100;
  localparam int unsigned FLASH_STEP_CYCLES = FLASH_STEP_MS * MS_CYCLES;
  localparam int unsigned MASK_TIME_NS = 21_000;
  localparam int unsigned MASK_CYCLES = MASK_TIME_NS / 25;
  localparam int unsigned RAMP_STEP_NS = 1_000;
  localparam int unsigned RAMP_STEP_CYCLES = RAMP_STEP_NS / 25;
  localparam int unsigned WIN1_MS = 1;
  localparam int unsigned WIN2_MS = 2;
  localparam int unsigned WIN3_MS = 5;

  // ==========================================================
  // field positions and reset values
  localparam int FAULT_LIMIT_BIT = 0;
  localparam int FAULT_MASK_BIT = 3;
  localparam int FAULT_TIMEOUT_BIT = 4;
  localparam logic [2:0] LOW_BATT_THRESH_RESET = 3'h0;
  localparam logic [1:0] LOW_BATT_WINDOW_RESET = 2'h3;
  localparam logic [2:0] INPUT_LIMIT_RESET = 3'h4;
  localparam logic [3:0] FLASH_DURATION_RESET = 4'hf;
  localparam logic [5:0] LEVEL_WIDTH_ONE = 6'h01;

  // ==========================================================
  // configuration carrier
  typedef struct packed
  {
    op_mode_t mode;
    logic strobe_hw;
    logic strobe_level;
    logic polarity_invert;
    logic [3:0] duration;
    logic [5:0] led1_flash;
    logic [5:0] led2_flash;
    logic [5:0] led1_mask;
    logic [5:0] led2_mask;
    logic [5:0] led1_torch;
    logic [5:0] led2_torch;
    logic [5:0] low_batt_level;
    logic [2:0] low_batt_thresh;
    logic [1:0] low_batt_window;
    logic limit_enable;
    logic [2:0] limit_value;
  } flash_cfg_t;
endpackage : flash_ctrl_pkg

// ===== core/level_ramp.sv
module level_ramp
  import flash_ctrl_pkg::*;
#(
  parameter int W = 6
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] target_in,
  input wire logic step_in,
  output logic [W-1:0] level_out
);
  // ==========================================================
  // rising targets climb one step per tick, falling ones jump
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      level_out <= '0;
    end
    else if (target_in <= level_out)
    begin
      level_out <= target_in;
    end
    else if (step_in)
    begin
      level_out <= level_out + W'(1);
    end
  end
endmodule : level_ramp

// ===== core/led_flash_mode_controller.sv
// Overview of operation
// - mode 011 is flash; a disabled LED gets no current
// - software strobe starts on a write; hardware strobe only from the pin
// - level mode: flash lasts while pin asserted, capped by duration limit
// - level mode overrun ends flash and sets timeout flag bit 4
// - edge mode: rising edge starts, duration limit ends the flash
// - four-bit duration field sets the limit, up to 1.6 s
// - polarity invert makes the trigger pin active low
// - standby with either enable set, then a torch pin rising edge, drives torch level
// - torch pin falling stops current and clears both enables
// - trigger while torch high hands over to flash; else no flash
// - a completed flash clears enables; the mode stays at flash (011)
// - transmit mask drops to mask level within 21 us
// - mask sets fault bit 3; release ramps current back gradually
// - modes 100/101: trigger drives LED1, torch pin LED2, flash or mask
// - mode 100 times OR of LEDs; expiry clears enables, mode 000
// - mode 001 regulates 5 V; mode 000 ends it
// - threshold code 000 disables detection, 001..111 select thresholds
// - low battery reduces flash current to low battery level
// - detection inside the window latches reduced current for the flash
// - input limit enable and value select the battery current limit
// - over-limit at start freezes current, flags bit 0, fills readback
// - mode 110: enabled LEDs toggle torch and low current by torch pin
// - reading the fault register clears bits whose cause has gone
// - chip enable rising edge resets config, enables, flash and faults; the current-limit latch keeps its value
module led_flash_mode_controller
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = FLASH_STEP_CYCLES,
  parameter int unsigned WIN_MS_CYCLES = MS_CYCLES
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire flash_cfg_t cfg_in,
  input wire logic cfg_write_in,
  input wire logic led1_enable_set_in,
  input wire logic led2_enable_set_in,
  input wire logic sw_strobe_in,
  input wire logic fault_read_in,
  input wire logic chip_enable_in,
  input wire logic flash_trigger_pin_in,
  input wire logic torch_pin_in,
  input wire logic transmit_mask_input_in,
  input wire logic battery_low_in,
  input wire logic battery_over_limit_in,
  output logic [7:0] fault_out,
  output op_mode_t mode_out,
  output logic led1_output_enable_out,
  output logic led2_output_enable_out,
  output logic [5:0] led1_current_out,
  output logic [5:0] led2_current_out,
  output logic [5:0] led1_actual_level_out,
  output logic [5:0] led2_actual_level_out,
  output logic boost_5v_out,
  output logic flash_active_out,
  output logic [2:0] low_battery_threshold_out,
  output logic [2:0] input_limit_value_out,
  output logic input_limit_enable_out
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] trig_s_q, torch_s_q, mask_s_q, ce_s_q, bl_s_q, ol_s_q;
  logic trig_q, torch_q, ce_q;
  flash_cfg_t cfg_q;
  logic trig_act, trig_rise, torch_fall, torch_rise, ce_rise, mask_act;
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      trig_s_q <= '0;
      torch_s_q <= '0;
      mask_s_q <= '0;
      // enable idles high: starting at one avoids a false rise at release
      ce_s_q <= '1;
      bl_s_q <= '0;
      ol_s_q <= '0;
      trig_q <= 1'b0;
      torch_q <= 1'b0;
      ce_q <= 1'b1;
    end
    else
    begin
      trig_s_q <= {trig_s_q[0], flash_trigger_pin_in};
      torch_s_q <= {torch_s_q[0], torch_pin_in};
      mask_s_q <= {mask_s_q[0], transmit_mask_input_in};
      ce_s_q <= {ce_s_q[0], chip_enable_in};
      bl_s_q <= {bl_s_q[0], battery_low_in};
      ol_s_q <= {ol_s_q[0], battery_over_limit_in};
      trig_q <= trig_act;
      torch_q <= torch_s_q[1];
      ce_q <= ce_s_q[1];
    end
  end

  logic batt_low, over_lim;
  assign trig_act = trig_s_q[1] ^ cfg_q.polarity_invert;
  assign trig_rise = trig_act & ~trig_q;
  assign torch_rise = torch_s_q[1] & ~torch_q;
  assign torch_fall = ~torch_s_q[1] & torch_q;
  assign ce_rise = ce_s_q[1] & ~ce_q;
  assign mask_act = mask_s_q[1];
  assign batt_low = bl_s_q[1] & (cfg_q.low_batt_thresh != 3'h0);
  assign over_lim = ol_s_q[1] & cfg_q.limit_enable;

  // ==========================================================
  // flash sequencer
  logic flash_q, torch_on_q, done_flash, timeout, indep_expire;
  logic [31:0] dur_cnt_q, win_cnt_q;
  logic [31:0] dur_limit, win_limit;
  logic flash_start, in_indep, indep_on;

  // duration code n lasts (n+1) steps; code 15 is the longest
  assign dur_limit = 32'(cfg_q.duration + 5'd1) * STEP_CYCLES;
  assign in_indep = (cfg_q.mode == MODE_INDEP_TO) ||
                    (cfg_q.mode == MODE_INDEP_NOTO);
  assign indep_on = in_indep & (trig_act | torch_s_q[1]);
  assign flash_start = ~flash_q &&
    (((cfg_q.mode == MODE_FLASH) &&
      (cfg_q.strobe_hw ? trig_rise : sw_strobe_in)) ||
     (torch_on_q && torch_s_q[1] && trig_rise));
  assign timeout = flash_q && cfg_q.strobe_hw && cfg_q.strobe_level &&
                   trig_act && (dur_cnt_q >= dur_limit - 1);
  assign done_flash = flash_q && ((dur_cnt_q >= dur_limit - 1) ||
    (cfg_q.strobe_hw && cfg_q.strobe_level && ~trig_act));
  assign indep_expire = (cfg_q.mode == MODE_INDEP_TO) && indep_on &&
                        (dur_cnt_q >= dur_limit - 1);

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      flash_q <= 1'b0;
      dur_cnt_q <= '0;
    end
    else if (ce_rise)
    begin
      flash_q <= 1'b0;
      dur_cnt_q <= '0;
    end
    else if (flash_start)
    begin
      flash_q <= 1'b1;
      dur_cnt_q <= '0;
    end
    else if (done_flash)
    begin
      flash_q <= 1'b0;
      dur_cnt_q <= '0;
    end
    else if (cfg_write_in && ~flash_q)
    begin
      dur_cnt_q <= '0; // a new mode starts its timer from zero
    end
    else if (flash_q || indep_on)
    begin
      dur_cnt_q <= dur_cnt_q + 32'd1;
    end
    else if (~in_indep)
    begin
      dur_cnt_q <= '0;
    end
  end

  // ==========================================================
  // configuration and mode register
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cfg_q <= '0;
      cfg_q.duration <= FLASH_DURATION_RESET;
      cfg_q.low_batt_window <= LOW_BATT_WINDOW_RESET;
      cfg_q.limit_value <= INPUT_LIMIT_RESET;
    end
    else if (ce_rise)
    begin
      cfg_q <= '0;
      cfg_q.duration <= FLASH_DURATION_RESET;
      cfg_q.low_batt_window <= LOW_BATT_WINDOW_RESET;
      cfg_q.limit_value <= INPUT_LIMIT_RESET;
    end
    else if (cfg_write_in)
    begin
      cfg_q <= cfg_in;
    end
    else if (indep_expire)
    begin
      cfg_q.mode <= MODE_STANDBY;
    end
  end

  // ==========================================================
  // per-LED enables: hardware clear wins over software set
  logic en1_q, en2_q, clr_en;
  assign clr_en = (done_flash & ~timeout) | timeout | indep_expire
                | (torch_on_q & torch_fall);
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      en1_q <= 1'b0;
      en2_q <= 1'b0;
    end
    else if (ce_rise || clr_en)
    begin
      en1_q <= 1'b0;
      en2_q <= 1'b0;
    end
    else if (cfg_write_in)
    begin
      en1_q <= led1_enable_set_in;
      en2_q <= led2_enable_set_in;
    end
  end

  // torch needs enables set first, then a fresh rising edge
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      torch_on_q <= 1'b0;
    end
    else if (torch_fall || ce_rise || flash_start || ~(en1_q | en2_q)
             || cfg_q.mode != MODE_STANDBY)
    begin
      torch_on_q <= 1'b0;
    end
    else if (torch_rise)
    begin
      torch_on_q <= 1'b1;
    end
  end

  // ==========================================================
  // mask, low battery window and dc limit
  logic lowbat_q, limit_q;
  always_comb
  begin
    unique case (cfg_q.low_batt_window)
      2'b01: win_limit = WIN1_MS * WIN_MS_CYCLES;
      2'b10: win_limit = WIN2_MS * WIN_MS_CYCLES;
      2'b11: win_limit = WIN3_MS * WIN_MS_CYCLES;
      default: win_limit = '1;
    endcase
  end
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      lowbat_q <= 1'b0;
      win_cnt_q <= '0;
    end
    else if (~flash_q)
    begin
      lowbat_q <= 1'b0;
      win_cnt_q <= '0;
    end
    else
    begin
      if (win_cnt_q != '1)
        win_cnt_q <= win_cnt_q + 32'd1;
      if (batt_low && win_cnt_q < win_limit)
        lowbat_q <= 1'b1;
    end
  end

  logic [5:0] lim1_q, lim2_q;
  logic [5:0] ramp1, ramp2;
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      limit_q <= 1'b0;
      lim1_q <= '0;
      lim2_q <= '0;
    end
    else if (flash_start)
    begin
      limit_q <= 1'b0;
    end
    else if (flash_q && over_lim && ~limit_q && win_cnt_q < WIN_MS_CYCLES)
    begin
      limit_q <= 1'b1;
      lim1_q <= ramp1;
      lim2_q <= ramp2;
    end
  end

  // ==========================================================
  // current targets
  logic [5:0] tgt1, tgt2, full1, full2;
  logic tick;
  logic [7:0] tick_q;
  assign tick = (tick_q == 8'(RAMP_STEP_CYCLES - 1));
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      tick_q <= '0;
    else
      tick_q <= tick ? 8'h00 : tick_q + 8'h01;
  end

  assign full1 = lowbat_q ? cfg_q.low_batt_level : cfg_q.led1_flash;
  assign full2 = lowbat_q ? cfg_q.low_batt_level : cfg_q.led2_flash;
  always_comb
  begin
    tgt1 = '0;
    tgt2 = '0;
    if (flash_q)
    begin
      tgt1 = mask_act ? cfg_q.led1_mask : full1;
      tgt2 = mask_act ? cfg_q.led2_mask : full2;
      if (limit_q)
      begin
        tgt1 = (lim1_q < tgt1) ? lim1_q : tgt1;
        tgt2 = (lim2_q < tgt2) ? lim2_q : tgt2;
      end
    end
    else if (torch_on_q || cfg_q.mode == MODE_ASSIST)
    begin
      tgt1 = cfg_q.led1_torch;
      tgt2 = cfg_q.led2_torch;
    end
    else if (in_indep)
    begin
      tgt1 = trig_act ? cfg_q.led1_flash : cfg_q.led1_mask;
      tgt2 = torch_s_q[1] ? cfg_q.led2_flash : cfg_q.led2_mask;
    end
    else if (cfg_q.mode == MODE_5V_TORCH)
    begin
      tgt1 = torch_s_q[1] ? cfg_q.led1_torch : LEVEL_WIDTH_ONE;
      tgt2 = torch_s_q[1] ? cfg_q.led2_torch : LEVEL_WIDTH_ONE;
    end
    if (!en1_q)
      tgt1 = '0;
    if (!en2_q)
      tgt2 = '0;
  end

  // drop is immediate (well under 21 us); climb is one step per us
  level_ramp #(.W(6)) u_ramp1
  (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .target_in(tgt1),
    .step_in(tick & ~limit_q),
    .level_out(ramp1)
  );
  level_ramp #(.W(6)) u_ramp2
  (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .target_in(tgt2),
    .step_in(tick & ~limit_q),
    .level_out(ramp2)
  );

  // ==========================================================
  // fault register: set wins over read clear
  logic [7:0] fault_q, fault_set, fault_hold;
  always_comb
  begin
    fault_set = '0;
    fault_set[FAULT_TIMEOUT_BIT] = timeout;
    fault_set[FAULT_MASK_BIT] = flash_q & mask_act;
    fault_set[FAULT_LIMIT_BIT] = flash_q & over_lim & ~limit_q &
                                 (win_cnt_q < WIN_MS_CYCLES);
    fault_hold = '0;
    fault_hold[FAULT_MASK_BIT] = mask_act;
    fault_hold[FAULT_LIMIT_BIT] = over_lim;
  end
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      fault_q <= '0;
    else if (ce_rise)
      fault_q <= '0;
    else if (fault_read_in)
      fault_q <= (fault_q & fault_hold) | fault_set;
    else
      fault_q <= fault_q | fault_set;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      led1_actual_level_out <= '0;
      led2_actual_level_out <= '0;
    end
    else
    begin
      led1_actual_level_out <= limit_q ? lim1_q : cfg_q.led1_flash;
      led2_actual_level_out <= limit_q ? lim2_q : cfg_q.led2_flash;
    end
  end

  assign fault_out = fault_q;
  assign mode_out = cfg_q.mode;
  assign led1_output_enable_out = en1_q;
  assign led2_output_enable_out = en2_q;
  assign led1_current_out = ramp1;
  assign led2_current_out = ramp2;
  assign boost_5v_out = (cfg_q.mode == MODE_FIXED5V) ||
                        (cfg_q.mode == MODE_5V_TORCH);
  assign flash_active_out = flash_q;
  assign low_battery_threshold_out = cfg_q.low_batt_thresh;
  assign input_limit_value_out = cfg_q.limit_value;
  assign input_limit_enable_out = cfg_q.limit_enable;
endmodule : led_flash_mode_controller

// ===== verif/flash_ctrl_properties.sv
module flash_ctrl_properties
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = 20
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire flash_cfg_t cfg_in,
  input wire logic transmit_mask_input_in,
  input wire logic [7:0] fault_out,
  input wire op_mode_t mode_out,
  input wire logic led1_output_enable_out,
  input wire logic led2_output_enable_out,
  input wire logic [5:0] led1_current_out,
  input wire logic [5:0] led2_current_out,
  input wire logic boost_5v_out,
  input wire logic flash_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // helpers
  int unsigned run_q;
  logic masked;
  logic in_flash;
  assign in_flash = flash_active_out && mode_out == MODE_FLASH;
  assign masked = in_flash && transmit_mask_input_in;
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      run_q <= 0;
    else if (in_flash)
      run_q <= run_q + 1;
    else
      run_q <= 0;
  end
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  // ======
  // properties
  a_flash_length_cap: assert property (run_q <= 16 * STEP_CYCLES)
    else $error("flash ran past the longest duration");
  a_dark_disabled_led: assert property (
    (in_flash && !led2_output_enable_out) [*2] |-> led2_current_out == 6'h00)
    else $error("disabled LED carries flash current");
  a_end_clears_enables: assert property (
    $fell(flash_active_out) && $past(mode_out) == MODE_FLASH
    |-> ##[0:1] !led1_output_enable_out && !led2_output_enable_out)
    else $error("enables survive end of flash");
  a_timeout_stops_flash: assert property (
    $rose(fault_out[FAULT_TIMEOUT_BIT])
    |-> ##[0:1] !flash_active_out && !led1_output_enable_out)
    else $error("timeout flag without flash shut off");
  a_boost_mode_match: assert property (
    boost_5v_out == (mode_out == MODE_FIXED5V || mode_out == MODE_5V_TORCH))
    else $error("boost output disagrees with mode");
  a_mask_sets_flag: assert property (
    masked [*5] |-> fault_out[FAULT_MASK_BIT])
    else $error("mask flag not raised");
  a_mask_level_cap: assert property (
    masked [*8] |-> led1_current_out <= cfg_in.led1_mask)
    else $error("current above mask level");
  a_standby_dark: assert property (
    (mode_out == MODE_STANDBY && !led1_output_enable_out) [*3]
    |-> led1_current_out == 6'h00)
    else $error("current in standby with LED disabled");
  c_flash: cover property ($rose(flash_active_out));
  c_timeout: cover property ($rose(fault_out[FAULT_TIMEOUT_BIT]));
  c_mask: cover property (masked [*5]);
endmodule : flash_ctrl_properties

// ===== verif/pin_model.sv
module pin_model
(
  input wire logic sys_clk_in,
  output logic trigger_out,
  output logic torch_out,
  output logic mask_out,
  output logic battery_low_out,
  output logic over_limit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // trigger and torch have pull-downs, so an idle far side reads low
  initial
  begin
    {trigger_out, torch_out, mask_out, battery_low_out, over_limit_out} = '0;
  end
  task automatic set_pins(input logic [4:0] v);
    {trigger_out, torch_out, mask_out, battery_low_out, over_limit_out} = v;
  endtask : set_pins
  // short sensor pulse; caller is just after an edge
  task automatic strobe(input logic inv, input int n);
    trigger_out = ~inv;
    repeat (n) @(posedge sys_clk_in);
    #2;
    trigger_out = inv;
  endtask : strobe
endmodule : pin_model

// ===== verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctrl_pkg::*;
  localparam int unsigned STEP = 20;
  logic sys_clk_in, reset_in, cfg_write_in, en1, en2, sw_strobe_in;
  logic fault_read_in, chip_enable_in, trig, torch, mask, blow, over;
  logic le1, le2, boost, act, lim_en;
  logic [7:0] fault_out;
  logic [5:0] i1, i2, a1, a2, p1, p2;
  logic [2:0] thr, lim;
  op_mode_t mode_out;
  flash_cfg_t c;
  int fail_count, n_compared, seed, n, lv;
  led_flash_mode_controller #(.STEP_CYCLES(STEP), .WIN_MS_CYCLES(10)) dut
  (
    .sys_clk_in, .reset_in, .cfg_in(c), .cfg_write_in,
    .led1_enable_set_in(en1), .led2_enable_set_in(en2), .sw_strobe_in,
    .fault_read_in, .chip_enable_in, .flash_trigger_pin_in(trig),
    .torch_pin_in(torch), .transmit_mask_input_in(mask),
    .battery_low_in(blow), .battery_over_limit_in(over),
    .fault_out, .mode_out, .led1_output_enable_out(le1),
    .led2_output_enable_out(le2), .led1_current_out(i1),
    .led2_current_out(i2), .led1_actual_level_out(a1),
    .led2_actual_level_out(a2), .boost_5v_out(boost),
    .flash_active_out(act), .low_battery_threshold_out(thr),
    .input_limit_value_out(lim), .input_limit_enable_out(lim_en)
  );
  pin_model pm
  (
    .sys_clk_in, .trigger_out(trig), .torch_out(torch), .mask_out(mask),
    .battery_low_out(blow), .over_limit_out(over)
  );
  // ======
  // tasks
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
    #2;
  endtask : tick
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string s, input logic [31:0] v, input int lo,
                         input int hi);
    n_compared++;
    if ((v >= lo && v <= hi) !== 1'b1)
    begin
      fail_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, v);
    end
  endtask : chk_rng
  task automatic wr(input op_mode_t m, input logic e_1, input logic e_2);
    c.mode = m;
    en1 = e_1;
    en2 = e_2;
    cfg_write_in = 1'b1;
    tick(1);
    cfg_write_in = 1'b0;
    tick(1);
  endtask : wr
  task automatic pulse_sw;
    sw_strobe_in = 1'b1;
    tick(1);
    sw_strobe_in = 1'b0;
    tick(1);
  endtask : pulse_sw
  task automatic read_faults;
    fault_read_in = 1'b1;
    tick(1);
    fault_read_in = 1'b0;
    tick(2);
  endtask : read_faults
  // cycles left in the running flash, with peak currents
  task automatic run_len;
    n = 0;
    p1 = '0;
    p2 = '0;
    while (act === 1'b1 && n < 2000)
    begin
      if (i1 > p1)
        p1 = i1;
      if (i2 > p2)
        p2 = i2;
      tick(1);
      n++;
    end
  endtask : run_len
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // ======
  // clock, watchdog, sequence
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    fail_count++;
    close_out();
  end
  initial
  begin
    {cfg_write_in, en1, en2, sw_strobe_in, fault_read_in} = '0;
    chip_enable_in = 1'b1;
    reset_in = 1'b1;
    fail_count = 0;
    n_compared = 0;
    seed = 7183;
    c = '0;
    c.duration = 4'hf;
    c.low_batt_window = 2'h3;
    c.limit_value = 3'h4;
    tick(2);
    reset_in = 1'b0;
    tick(1);
    chk("fault", 8'h00, fault_out);
    chk("threshold", 8'h00, thr);
    chk("limit value", 8'h04, lim);
    chk("limit enable", 8'h00, lim_en);
    for (int r = 0; r < 3; r++)
    begin
      lv = $random(seed);
      c.led1_flash = 6'(1 + lv[7:0] % 5);
      c.led2_flash = 6'(1 + lv[15:8] % 5);
      c.duration = 4'(11 + lv[23:16] % 5);
      wr(MODE_FLASH, 1'b1, lv[24]);
      pulse_sw();
      chk("sw start", 8'h01, act);
      run_len();
      lv = (c.duration + 1) * STEP;
      chk_rng("sw length", n, lv - 2, lv + 1);
      chk("led1 peak", c.led1_flash, p1);
      chk("led2 peak", en2 ? c.led2_flash : 6'h00, p2);
      chk("enables", 8'h00, {le1, le2});
    end
    // hardware level mode, both trigger polarities
    for (int p = 0; p < 2; p++)
    begin
      c.strobe_hw = 1'b1;
      c.strobe_level = 1'b1;
      c.polarity_invert = p[0];
      c.duration = 4'h3;
      wr(MODE_STANDBY, 1'b0, 1'b0);
      pm.set_pins({p[0], 4'h0});
      tick(4);
      wr(MODE_FLASH, 1'b1, 1'b1);
      pulse_sw();
      tick(4);
      chk("sw ignored", 8'h00, act);
      pm.set_pins({~p[0], 4'h0});
      tick(30);
      pm.set_pins({p[0], 4'h0});
      run_len();
      chk_rng("level tail", n, 1, 6);
      chk("no timeout", 8'h00, fault_out[4]);
      wr(MODE_FLASH, 1'b1, 1'b1);
      pm.set_pins({~p[0], 4'h0});
      tick(5);
      run_len();
      chk_rng("timeout length", n, 74, 82);
      tick(2);
      chk("timeout flag", 8'h01, fault_out[4]);
      pm.set_pins({p[0], 4'h0});
      tick(4);
      read_faults();
      chk("flag cleared", 8'h00, fault_out[4]);
    end
    c.strobe_level = 1'b0;
    c.polarity_invert = 1'b0;
    c.duration = 4'h1;
    wr(MODE_STANDBY, 1'b0, 1'b0);
    pm.set_pins(5'h00);
    tick(4);
    wr(MODE_FLASH, 1'b1, 1'b1);
    pm.strobe(1'b0, 3);
    tick(3);
    run_len();
    chk_rng("edge length", n, 34, 40);
    // transmit mask in a software flash
    c.strobe_hw = 1'b0;
    c.duration = 4'hf;
    c.led1_flash = 6'h04;
    c.led1_mask = 6'h01;
    wr(MODE_FLASH, 1'b1, 1'b0);
    pulse_sw();
    tick(170);
    chk("full level", 8'h04, i1);
    pm.set_pins(5'b00100);
    tick(10);
    chk("mask level", 8'h01, i1);
    chk("mask flag", 8'h01, fault_out[3]);
    pm.set_pins(5'h00);
    tick(60);
    chk_rng("ramp back", i1, 1, 3);
    run_len();
    read_faults();
    chk("mask cleared", 8'h00, fault_out[3]);
    // torch through the torch pin
    c.led1_torch = 6'h02;
    c.led2_torch = 6'h01;
    wr(MODE_STANDBY, 1'b1, 1'b1);
    pm.set_pins(5'b01000);
    tick(100);
    chk("torch led1", 8'h02, i1);
    chk("torch led2", 8'h01, i2);
    pm.set_pins(5'h00);
    tick(6);
    chk("torch enables", 8'h00, {le1, le2});
    chk("torch off", 8'h00, i1);
    pm.set_pins(5'b10000);
    tick(6);
    chk("no flash after torch", 8'h00, act);
    wr(MODE_STANDBY, 1'b1, 1'b1);
    pm.set_pins(5'b01000);
    tick(6);
    pm.set_pins(5'b11000);
    tick(6);
    chk("torch to flash", 8'h01, act);
    pm.set_pins(5'h00);
    run_len();
    chk("handover enables", 8'h00, {le1, le2});
    // independent trigger modes
    c.led1_flash = 6'h01;
    c.led1_mask = 6'h00;
    c.duration = 4'h0;
    wr(MODE_INDEP_NOTO, 1'b1, 1'b1);
    pm.set_pins(5'b10000);
    tick(60);
    chk("indep flash", 8'h01, i1);
    chk("no timer", 8'h03, {le1, le2});
    pm.set_pins(5'h00);
    tick(6);
    chk("indep mask", 8'h00, i1);
    wr(MODE_INDEP_TO, 1'b1, 1'b1);
    pm.set_pins(5'b01000);
    tick(10);
    chk("timer running", MODE_INDEP_TO, mode_out);
    tick(30);
    chk("timer mode", MODE_STANDBY, mode_out);
    chk("timer enables", 8'h00, {le1, le2});
    pm.set_pins(5'h00);
    // battery current over the limit at flash start
    c.limit_enable = 1'b1;
    c.led1_flash = 6'h03;
    c.duration = 4'hf;
    pm.set_pins(5'b00001);
    tick(4);
    wr(MODE_FLASH, 1'b1, 1'b0);
    pulse_sw();
    tick(60);
    chk("limit flag", 8'h01, fault_out[0]);
    chk_rng("readback", a1, 0, 2);
    chk("readback 2", 8'h00, a2);
    pm.set_pins(5'h00);
    run_len();
    tick(4);
    read_faults();
    chk("faults clear", 8'h00, fault_out);
    c.limit_enable = 1'b0;
    // low battery inside a 1 ms window latches the reduced level
    c.low_batt_thresh = 3'h1;
    c.low_batt_level = 6'h01;
    c.low_batt_window = 2'h1;
    c.led1_flash = 6'h04;
    pm.set_pins(5'b00010);
    tick(4);
    wr(MODE_FLASH, 1'b1, 1'b0);
    pulse_sw();
    pm.set_pins(5'h00);
    tick(200);
    chk("low battery level", c.low_batt_level, i1);
    run_len();
    // fixed 5 V modes
    c.led1_torch = 6'h03;
    wr(MODE_FIXED5V, 1'b0, 1'b0);
    chk("boost on", 8'h01, boost);
    wr(MODE_STANDBY, 1'b0, 1'b0);
    chk("boost off", 8'h00, boost);
    wr(MODE_5V_TORCH, 1'b1, 1'b1);
    tick(60);
    chk("5v low level", LEVEL_WIDTH_ONE, i1);
    pm.set_pins(5'b01000);
    tick(90);
    chk("5v torch level", c.led1_torch, i1);
    pm.set_pins(5'h00);
    // chip enable rising edge restores defaults
    c.low_batt_thresh = 3'h5;
    c.limit_value = 3'h1;
    wr(MODE_STANDBY, 1'b0, 1'b0);
    chk("threshold set", 8'h05, thr);
    chip_enable_in = 1'b0;
    tick(4);
    chip_enable_in = 1'b1;
    tick(6);
    chk("threshold default", 8'h00, thr);
    chk("limit default", 8'h04, lim);
    close_out();
  end
endmodule : tb

bind led_flash_mode_controller flash_ctrl_properties
  #(.STEP_CYCLES(STEP_CYCLES)) props
(
  .sys_clk_in, .reset_in, .cfg_in, .transmit_mask_input_in, .fault_out,
  .mode_out, .led1_output_enable_out, .led2_output_enable_out,
  .led1_current_out, .led2_current_out, .boost_5v_out, .flash_active_out
);
